//--- acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// Sample and channel widths of the converter command and response streams.
`define ACS_SAMPLE_W   12
`define ACS_CHAN_W     5
`define ACS_SLOT_W     6
`define ACS_MAX_SLOTS  64

// Channel code that marks an empty slot on the second converter.
`define ACS_EMPTY_CH   5'h1F
// Channel code of the on-die temperature channel (first converter only).
`define ACS_TEMP_CH    5'h11

// Reset values of the control state.
`define ACS_SLOT_RST   6'h00
`define ACS_SAMPLE_RST 12'h000

`endif

//--- acs_pkg.sv
`default_nettype none
`include "acs_defines.svh"

package acs_pkg;

    typedef logic [`ACS_SAMPLE_W-1:0] acs_sample_t;
    typedef logic [`ACS_CHAN_W-1:0]   acs_chan_t;
    typedef logic [`ACS_SLOT_W-1:0]   acs_slot_t;

    // One finished slot: both converters' results plus its position.
    typedef struct packed {
        acs_slot_t   slot;
        logic        eop;
        acs_sample_t s1;
        acs_sample_t s2;
    } acs_word_s;

    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_RUN,
        ACS_DRAIN
    } acs_state_e;

endpackage : acs_pkg

`default_nettype wire

//--- acs_stream_if.sv
`timescale 1ns/1ps
`default_nettype none

// Valid/ready word stream between the sequencer and its output buffer.
interface acs_stream_if;
    import acs_pkg::*;
    logic      valid;
    logic      ready;
    acs_word_s word;
    modport src (output valid, output word, input ready);
    modport snk (input valid, input word, output ready);
endinterface : acs_stream_if

`default_nettype wire

//--- acs_buf2.sv
`timescale 1ns/1ps
`default_nettype none

// Two-entry buffer; a receiver stall fills it and then drops in.ready.
module acs_buf2 (
    input  wire logic CLK,
    input  wire logic RST_N,
    acs_stream_if.snk in,
    acs_stream_if.src out
);
    import acs_pkg::*;

    acs_word_s mem_r [2];
    acs_word_s mem_nxt [2];
    logic      wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic      push, pop;

    // Honest full and empty come straight from the fill count.
    assign in.ready  = (cnt_r != 2'h2);
    assign out.valid = (cnt_r != 2'h0);
    assign out.word  = mem_r[rp_r];
    assign push      = in.valid && in.ready;
    assign pop       = out.valid && out.ready;

    // Next pointers, count and storage.
    always_comb begin
        mem_nxt = mem_r;
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = in.word;
            wp_nxt        = ~wp_r;
        end
        if (pop) begin
            rp_nxt = ~rp_r;
        end
        case ({push, pop})
            2'b10:   cnt_nxt = cnt_r + 2'h1;
            2'b01:   cnt_nxt = cnt_r - 2'h1;
            default: cnt_nxt = cnt_r;
        endcase
    end

    // Storage needs no reset; only valid entries are ever read out.
    always_ff @(posedge CLK) begin
        mem_r <= mem_nxt;
    end

    // Pointers and count.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule : acs_buf2

`default_nettype wire

//--- acs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

module acs_sequencer #(
    parameter int                         SEQ_LEN   = 4,
    parameter bit                         DUAL      = 1'b1,
    parameter logic [64*`ACS_CHAN_W-1:0]  SLOT_CH1  = '0,
    parameter logic [64*`ACS_CHAN_W-1:0]  SLOT_CH2  = '0,
    parameter logic [31:0]                THR_EN1   = 32'h0000_0000,
    parameter logic [31:0]                THR_EN2   = 32'h0000_0000,
    parameter logic [`ACS_SAMPLE_W-1:0]   THR_HI1   = 12'hFFF,
    parameter logic [`ACS_SAMPLE_W-1:0]   THR_LO1   = 12'h000,
    parameter logic [`ACS_SAMPLE_W-1:0]   THR_HI2   = 12'hFFF,
    parameter logic [`ACS_SAMPLE_W-1:0]   THR_LO2   = 12'h000
) (
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    input  wire logic                 START,
    input  wire logic                 STOP,
    input  wire logic                 CONTINUOUS,
    output logic                      BUSY,
    output logic                      CMD_VALID,
    input  wire logic                 CMD_READY,
    output acs_pkg::acs_chan_t        CMD_CH1,
    output acs_pkg::acs_chan_t        CMD_CH2,
    input  wire logic                 RSP_VALID,
    input  wire acs_pkg::acs_sample_t RSP_DATA1,
    input  wire acs_pkg::acs_sample_t RSP_DATA2,
    output logic                      OUT_VALID,
    input  wire logic                 OUT_READY,
    output acs_pkg::acs_slot_t        OUT_SLOT,
    output logic                      OUT_EOP,
    output acs_pkg::acs_sample_t      OUT_DATA1,
    output acs_pkg::acs_sample_t      OUT_DATA2,
    input  wire acs_pkg::acs_slot_t   RD_ADDR,
    output acs_pkg::acs_sample_t      RD_DATA1,
    output acs_pkg::acs_sample_t      RD_DATA2,
    output logic                      BLOCK_READY,
    input  wire logic                 BLOCK_ACK,
    output logic                      ROUND_DONE,
    output logic [1:0]                VIOL_HI,
    output logic [1:0]                VIOL_LO
);
    import acs_pkg::*;

    // Slot table lookup; the tables are fixed at elaboration.
    function automatic acs_chan_t slot_chan(
        input logic [64*`ACS_CHAN_W-1:0] tbl,
        input acs_slot_t                 idx
    );
        slot_chan = tbl[idx*`ACS_CHAN_W +: `ACS_CHAN_W];
    endfunction : slot_chan

    // Second converter's channel for a slot, forced empty where needed.
    function automatic acs_chan_t chan2_of(input acs_slot_t idx);
        acs_chan_t c;
        c = slot_chan(SLOT_CH2, idx);
        if (slot_chan(SLOT_CH1, idx) == `ACS_TEMP_CH) begin
            c = `ACS_EMPTY_CH;
        end
        if (!DUAL || c == `ACS_TEMP_CH) begin
            c = `ACS_EMPTY_CH;
        end
        chan2_of = c;
    endfunction : chan2_of

    // Threshold test against one converter's limits and channel mask.
    function automatic logic [1:0] thr_check(
        input acs_sample_t s,
        input acs_chan_t   ch,
        input logic [31:0] en,
        input acs_sample_t hi,
        input acs_sample_t lo
    );
        // A value equal to a limit is not a violation.
        thr_check = 2'b00;
        if (en[ch]) begin
            thr_check = {s > hi, s < lo};
        end
    endfunction : thr_check

    // Shared sequence length
    // One length serves both converters; an out-of-range setting is
    // clamped into 1..64 rather than left to wrap the slot pointer.
    localparam int SEQ_USED = (SEQ_LEN < 1) ? 1
                            : (SEQ_LEN > `ACS_MAX_SLOTS) ? `ACS_MAX_SLOTS
                            : SEQ_LEN;
    localparam acs_slot_t LAST_SLOT = acs_slot_t'(SEQ_USED - 1);

    // Slot pointer, answer slot, stop request and round bookkeeping.
    acs_state_e  state_r, state_nxt;
    acs_slot_t   idx_r, idx_nxt;
    acs_slot_t   rsp_idx_r, rsp_idx_nxt;
    logic        pend_r, pend_nxt;
    logic        stop_r, stop_nxt;
    logic        blk_r, blk_nxt;
    logic        done_r, done_nxt;
    logic [1:0]  hi_r, hi_nxt, lo_r, lo_nxt;
    acs_sample_t rd1_r, rd2_r;
    acs_sample_t ram1_r [`ACS_MAX_SLOTS];
    acs_sample_t ram2_r [`ACS_MAX_SLOTS];
    acs_sample_t s1, s2;
    logic        cmd_take, rsp_last;
    logic [1:0]  t1, t2;

    acs_stream_if buf_in ();
    acs_stream_if buf_out ();

    // A command also needs room downstream, since answers cannot stall.
    // One command outstanding
    assign CMD_VALID = (state_r == ACS_RUN) && !pend_r && buf_in.ready;
    assign cmd_take  = CMD_VALID && CMD_READY;
    assign CMD_CH1   = slot_chan(SLOT_CH1, idx_r);
    assign CMD_CH2   = chan2_of(idx_r);

    assign s1 = RSP_DATA1;
    assign s2 = (chan2_of(rsp_idx_r) == `ACS_EMPTY_CH) ? `ACS_SAMPLE_RST
                                                       : RSP_DATA2;
    assign rsp_last = RSP_VALID && (rsp_idx_r == LAST_SLOT);

    assign t1 = thr_check(s1, slot_chan(SLOT_CH1, rsp_idx_r),
                          THR_EN1, THR_HI1, THR_LO1);
    assign t2 = DUAL ? thr_check(s2, chan2_of(rsp_idx_r),
                                 THR_EN2, THR_HI2, THR_LO2) : 2'b00;

    assign buf_in.valid      = RSP_VALID;
    assign buf_in.word       = '{slot: rsp_idx_r,
                                 eop:  (rsp_idx_r == LAST_SLOT),
                                 s1:   s1,
                                 s2:   s2};
    assign buf_out.ready     = OUT_READY;
    assign OUT_VALID         = buf_out.valid;
    assign OUT_SLOT          = buf_out.word.slot;
    assign OUT_EOP           = buf_out.word.eop;
    assign OUT_DATA1         = buf_out.word.s1;
    assign OUT_DATA2         = buf_out.word.s2;

    // The buffer absorbs a receiver stall; commands pause while it is
    // full, so an answer that cannot be held back is never dropped.
    acs_buf2 u_buf (
        .CLK   (CLK),
        .RST_N (RST_N),
        .in    (buf_in),
        .out   (buf_out)
    );

    // Sequencing state, slot pointer and round bookkeeping.
    always_comb begin
        state_nxt   = state_r;
        idx_nxt     = idx_r;
        rsp_idx_nxt = rsp_idx_r;
        pend_nxt    = pend_r;
        stop_nxt    = stop_r;
        blk_nxt     = blk_r;
        done_nxt    = 1'b0;
        hi_nxt      = 2'b00;
        lo_nxt      = 2'b00;
        // An answer always closes the pending command.
        if (RSP_VALID) begin
            pend_nxt = 1'b0;
            hi_nxt   = {t2[1], t1[1]};
            lo_nxt   = {t2[0], t1[0]};
        end
        // Taking a command advances the pointer and remembers its slot.
        if (cmd_take) begin
            pend_nxt    = 1'b1;
            rsp_idx_nxt = idx_r;
            if (idx_r == LAST_SLOT) begin
                idx_nxt = `ACS_SLOT_RST;
            end else begin
                idx_nxt = idx_r + 6'h01;
            end
        end
        // Host acknowledge clears; a round finishing now wins.
        if (BLOCK_ACK) begin
            blk_nxt = 1'b0;
        end
        if (rsp_last) begin
            blk_nxt  = 1'b1;
            done_nxt = 1'b1;
        end
        case (state_r)
            ACS_IDLE: begin
                if (START && !blk_r) begin
                    state_nxt = ACS_RUN;
                    idx_nxt   = `ACS_SLOT_RST;
                end
            end
            ACS_RUN: begin
                // A stop waits until no command is left on offer, so an
                // offered command is never withdrawn before it is taken.
                if (STOP) begin
                    stop_nxt = 1'b1;
                end
                if (((STOP || stop_r) && (!CMD_VALID || cmd_take))
                    || (cmd_take && idx_r == LAST_SLOT && !CONTINUOUS)) begin
                    state_nxt = ACS_DRAIN;
                    stop_nxt  = 1'b0;
                end
            end
            ACS_DRAIN: begin
                if (!pend_nxt) begin
                    state_nxt = ACS_IDLE;
                end
            end
            default: state_nxt = ACS_IDLE;
        endcase
    end

    // Control registers.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r   <= ACS_IDLE;
            idx_r     <= `ACS_SLOT_RST;
            rsp_idx_r <= `ACS_SLOT_RST;
            pend_r    <= 1'b0;
            stop_r    <= 1'b0;
            blk_r     <= 1'b0;
            done_r    <= 1'b0;
            hi_r      <= 2'b00;
            lo_r      <= 2'b00;
        end else begin
            state_r   <= state_nxt;
            idx_r     <= idx_nxt;
            rsp_idx_r <= rsp_idx_nxt;
            pend_r    <= pend_nxt;
            stop_r    <= stop_nxt;
            blk_r     <= blk_nxt;
            done_r    <= done_nxt;
            hi_r      <= hi_nxt;
            lo_r      <= lo_nxt;
        end
    end

    // Round storage is plain flops without reset to keep it small.
    // Round stored
    always_ff @(posedge CLK) begin
        if (RSP_VALID) begin
            ram1_r[rsp_idx_r] <= s1;
            ram2_r[rsp_idx_r] <= s2;
        end
    end

    // Registered host read port, one cycle of latency.
    // An entry not yet written this round still holds the last round's
    // value, so the host should read only while BLOCK_READY is high.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd1_r <= `ACS_SAMPLE_RST;
            rd2_r <= `ACS_SAMPLE_RST;
        end else begin
            rd1_r <= ram1_r[RD_ADDR];
            rd2_r <= ram2_r[RD_ADDR];
        end
    end

    // Status and read outputs other than BUSY come straight from their registers; BUSY is decoded from state_r.
    assign RD_DATA1    = rd1_r;
    assign RD_DATA2    = rd2_r;
    assign BLOCK_READY = blk_r;
    assign ROUND_DONE  = done_r;
    assign VIOL_HI     = hi_r;
    assign VIOL_LO     = lo_r;
    assign BUSY        = (state_r != ACS_IDLE);

endmodule : acs_sequencer

`default_nettype wire

//--- acs_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

// Port-level checks of the command, output and status handshakes.
module acs_seq_properties #(
    parameter int SEQ_LEN = 4
) (
    input wire logic                 CLK,
    input wire logic                 RST_N,
    input wire logic                 CMD_VALID,
    input wire logic                 CMD_READY,
    input wire acs_pkg::acs_chan_t   CMD_CH1,
    input wire acs_pkg::acs_chan_t   CMD_CH2,
    input wire logic                 RSP_VALID,
    input wire logic                 OUT_VALID,
    input wire logic                 OUT_READY,
    input wire acs_pkg::acs_slot_t   OUT_SLOT,
    input wire logic                 OUT_EOP,
    input wire acs_pkg::acs_sample_t OUT_DATA1,
    input wire logic                 BLOCK_READY,
    input wire logic                 BLOCK_ACK,
    input wire logic                 ROUND_DONE,
    input wire logic [1:0]           VIOL_HI,
    input wire logic [1:0]           VIOL_LO
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence cmd_take; CMD_VALID && CMD_READY; endsequence
    sequence cmd_wait; CMD_VALID && !CMD_READY; endsequence
    sequence out_wait; OUT_VALID && !OUT_READY; endsequence

    // A word or command must never change or vanish before it is taken.
    cmd_hold_a: assert property (cmd_wait |=> CMD_VALID
        && $stable(CMD_CH1) && $stable(CMD_CH2)) else $error("cmd changed");
    one_cmd_a: assert property (cmd_take |=> !CMD_VALID)
        else $error("second cmd");
    temp_empty_a: assert property (CMD_VALID
        && CMD_CH1 == `ACS_TEMP_CH |-> CMD_CH2 == `ACS_EMPTY_CH)
        else $error("temp slot not empty");
    out_hold_a: assert property (out_wait |=> OUT_VALID
        && $stable(OUT_DATA1) && $stable(OUT_SLOT)) else $error("word lost");
    rsp_out_a: assert property (RSP_VALID |=> OUT_VALID)
        else $error("response not offered");
    eop_slot_a: assert property (OUT_VALID
        |-> OUT_EOP == (OUT_SLOT == SEQ_LEN - 1)) else $error("bad eop");
    done_pulse_a: assert property (ROUND_DONE
        |-> BLOCK_READY ##1 !ROUND_DONE) else $error("bad round pulse");
    ack_clear_a: assert property (BLOCK_ACK && !RSP_VALID
        |=> !BLOCK_READY) else $error("block not cleared");
    viol_cause_a: assert property (
        (VIOL_HI != 2'h0 || VIOL_LO != 2'h0) |-> $past(RSP_VALID))
        else $error("violation without sample");
endmodule : acs_seq_properties

bind acs_sequencer acs_seq_properties #(.SEQ_LEN(SEQ_LEN)) u_props (
    .CLK(CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD_CH1(CMD_CH1), .CMD_CH2(CMD_CH2),
    .RSP_VALID(RSP_VALID), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
    .OUT_SLOT(OUT_SLOT), .OUT_EOP(OUT_EOP), .OUT_DATA1(OUT_DATA1),
    .BLOCK_READY(BLOCK_READY), .BLOCK_ACK(BLOCK_ACK),
    .ROUND_DONE(ROUND_DONE), .VIOL_HI(VIOL_HI), .VIOL_LO(VIOL_LO));

`default_nettype wire

//--- acs_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

// Converter control model: one command in flight, answer after DELAY+1.
module acs_conv_model (
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    input  wire logic [7:0]           DELAY,
    input  wire logic                 CMD_VALID,
    output logic                      CMD_READY,
    input  wire acs_pkg::acs_chan_t   CMD_CH1,
    input  wire acs_pkg::acs_chan_t   CMD_CH2,
    output logic                      RSP_VALID,
    output acs_pkg::acs_sample_t      RSP_DATA1,
    output acs_pkg::acs_sample_t      RSP_DATA2
);
    import acs_pkg::*;
    logic        busy_r;
    logic [7:0]  cnt_r;
    logic [1:0]  gap_r;
    acs_chan_t   c1_r, c2_r;
    acs_sample_t v1, v2;

    // One command at a time; DELAY[7] adds a ready gap after answers.
    // A request offered inside the gap simply waits for ready.
    assign CMD_READY = !busy_r && (gap_r == 2'h0);
    assign v1 = {c1_r, 7'h05};
    assign v2 = (c2_r == `ACS_EMPTY_CH) ? 12'h000 : {c2_r, 7'h0A};
    // Outside a response the lines show the inverse, so stale data fails.
    assign RSP_DATA1 = RSP_VALID ? v1 : ~v1;
    assign RSP_DATA2 = RSP_VALID ? v2 : ~v2;

    // Commands come from whatever logic drives the command port.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
            gap_r <= 2'h0;
            c1_r <= 5'h00;
            c2_r <= 5'h00;
            RSP_VALID <= 1'b0;
        end else begin
            RSP_VALID <= 1'b0;
            if (gap_r != 2'h0) begin
                gap_r <= gap_r - 2'h1;
            end
            if (CMD_VALID && CMD_READY) begin
                busy_r <= 1'b1;
                cnt_r <= DELAY;
                c1_r <= CMD_CH1;
                c2_r <= CMD_CH2;
            end else if (busy_r && cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end else if (busy_r) begin
                busy_r <= 1'b0;
                RSP_VALID <= 1'b1;
                gap_r <= {DELAY[7], 1'b0};
            end
        end
    end
endmodule : acs_conv_model

`default_nettype wire

//--- acs_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer_tb_top;
    import acs_pkg::*;
    localparam logic [19:0] T1 = {5'h05, 5'h11, 5'h03, 5'h03};
    // Slot 2 of the second table is a real channel that the temperature
    // slot of the first table must override to empty.
    localparam logic [19:0] T2 = {5'h09, 5'h0C, 5'h07, 5'h02};
    logic        clk, rst_n, start, stop, cont, ordy, ack;
    logic        busy, cval, crdy, rval, oval, eop, brdy, rdone;
    logic [1:0]  vhi, vlo;
    logic [7:0]  dly;
    acs_chan_t   ch1, ch2;
    acs_slot_t   oslot, raddr;
    acs_sample_t r1, r2, q1, q2, rd1, rd2;
    acs_word_s   got[$];
    int          n_mismatch, tests_run, nvh, nvl, nrd;

    acs_sequencer #(.SEQ_LEN(4), .SLOT_CH1(T1), .SLOT_CH2(T2),
        .THR_EN1(32'h0000_0008), .THR_HI1(12'h180),
        .THR_EN2(32'h0000_0200), .THR_LO2(12'h500)) u_dut (
        .CLK(clk), .RST_N(rst_n), .START(start), .STOP(stop),
        .CONTINUOUS(cont), .BUSY(busy), .CMD_VALID(cval),
        .CMD_READY(crdy), .CMD_CH1(ch1), .CMD_CH2(ch2), .RSP_VALID(rval),
        .RSP_DATA1(r1), .RSP_DATA2(r2), .OUT_VALID(oval), .OUT_READY(ordy),
        .OUT_SLOT(oslot), .OUT_EOP(eop), .OUT_DATA1(q1), .OUT_DATA2(q2),
        .RD_ADDR(raddr), .RD_DATA1(rd1), .RD_DATA2(rd2), .BLOCK_READY(brdy),
        .BLOCK_ACK(ack), .ROUND_DONE(rdone), .VIOL_HI(vhi), .VIOL_LO(vlo));
    acs_conv_model u_conv (.CLK(clk), .RST_N(rst_n), .DELAY(dly),
        .CMD_VALID(cval), .CMD_READY(crdy), .CMD_CH1(ch1), .CMD_CH2(ch2),
        .RSP_VALID(rval), .RSP_DATA1(r1), .RSP_DATA2(r2));

    // Expected word of a slot; a temperature slot empties the second side.
    function automatic acs_word_s ew(input int i);
        acs_chan_t a, b;
        a = T1[i*5 +: 5];
        b = (a == 5'h11) ? 5'h1F : T2[i*5 +: 5];
        ew = '{acs_slot_t'(i), i == 3, {a, 7'h05},
               (b == 5'h1F) ? 12'h000 : {b, 7'h0A}};
    endfunction : ew

    // Collect taken words and weigh violation bits so a swapped bit shows.
    always @(posedge clk) begin
        if (oval && ordy) got.push_back('{oslot, eop, q1, q2});
        nvh += vhi;
        nvl += vlo;
        nrd += rdone;
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic close_out;
        $display("Counts: %0d mismatches, %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic wait_idle;
        int k;
        for (k = 0; k < 4000 && busy !== 1'b0; k++) @(negedge clk);
        if (busy !== 1'b0) begin
            n_mismatch++;
            close_out();
        end
        // The last word and the registered pulses land one edge after idle.
        repeat (2) @(negedge clk);
    endtask : wait_idle

    task automatic go;
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        repeat (2) @(negedge clk);
    endtask : go

    task automatic give_ack;
        @(posedge clk) ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        @(negedge clk);
        chk(brdy, 1'b0);
    endtask : give_ack

    // One round, then the host reads the stored block back.
    task automatic t_single(input logic [7:0] d);
        acs_word_s w;
        @(posedge clk) dly <= d;
        got.delete();
        nvh = 0;
        nvl = 0;
        nrd = 0;
        go();
        wait_idle();
        chk(got.size(), 4);
        foreach (got[i]) chk(got[i], ew(i));
        chk({nvh[7:0], nvl[7:0], nrd[7:0]}, 24'h020201);
        chk(brdy, 1'b1);
        go();
        chk(busy, 1'b0);
        for (int i = 0; i < 4; i++) begin
            w = ew(i);
            @(posedge clk) raddr <= acs_slot_t'(i);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk({rd1, rd2}, {w.s1, w.s2});
        end
        give_ack();
    endtask : t_single

    // Continuous run with the receiver stalled, then drained and stopped.
    task automatic t_stall;
        int k;
        @(posedge clk) cont <= 1'b1;
        ordy <= 1'b0;
        dly <= 8'h03;
        got.delete();
        go();
        repeat (60) @(negedge clk);
        chk({busy, oval, got.size() == 0}, 3'h7);
        @(posedge clk) ordy <= 1'b1;
        for (k = 0; k < 2000 && got.size() < 9; k++) @(negedge clk);
        chk(got.size() > 8, 1'b1);
        if (got.size() < 9) begin
            close_out();
        end
        @(posedge clk) stop <= 1'b1;
        @(posedge clk) stop <= 1'b0;
        wait_idle();
        foreach (got[i]) chk(got[i], ew(i % 4));
        give_ack();
    endtask : t_stall

    initial begin
        {start, stop, cont, ack, rst_n} = 5'h00;
        ordy = 1'b1;
        dly = 8'h03;
        raddr = 6'h00;
        repeat (9) @(posedge clk);
        @(negedge clk);
        chk({busy, cval, oval, brdy, rdone, vhi, vlo}, 0);
        chk({rd1, rd2}, 0);
        @(posedge clk) rst_n <= 1'b1;
        t_single(8'h03);
        t_single(8'h82);
        t_stall();
        close_out();
    end
endmodule : acs_sequencer_tb_top

`default_nettype wire
